// ===== hw/pcu_top.sv
// pcu_top: clock configuration register, lock tracking and clock dividers
`timescale 1ns/1ps
module pcu_top
  import pcu_pkg::*;
#(
  parameter int unsigned LOCK_CYC = PCU_LOCK_CYCLES
) (
  input  wire logic        clk_i,                      // 10 MHz system clock
  input  wire logic        srst_i,                     // sync reset, high
  input  wire logic [11:0] paddr_i,                    // apb address
  input  wire logic        psel_i,                     // apb select
  input  wire logic        penable_i,                  // apb enable
  input  wire logic        pwrite_i,                   // apb write
  input  wire logic [31:0] pwdata_i,                   // apb write data
  output logic      [31:0] prdata_o,                   // apb read data
  output logic             pready_o,                   // apb ready
  output logic             pslverr_o,                  // apb error
  input  wire logic        crystal_input_i,            // crystal pin
  input  wire logic        loop_clk_i,                 // vco output pin
  input  wire logic        external_audio_clock_pin_i, // external audio clock
  input  wire logic        audio_strap_i,              // strap, high = pin
  output logic             processor_clock_o,          // processor clock
  output logic             system_half_clock_o,        // half processor clock
  output logic             dac_master_clock_one_o,     // dac clock one
  output logic             dac_master_clock_two_o,     // dac clock two
  output logic             audio_clock_o,              // audio clock
  output logic             loop_locked_o,              // loop lock state
  output logic             loop_power_down_o,          // loop power down
  output logic             sleep_o,                    // device sleep
  output logic             loop_in_half_o,             // loop input halved
  output logic      [4:0]  reference_divider_o,        // loop reference divider
  output logic      [7:0]  feedback_divider_o          // loop feedback divider
);

  logic [31:0] cfg_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] prdata_q;
  logic        locked_q;
  logic [31:0] lock_cnt_q;
  pcu_mode_t   mode_q;
  logic [3:0]  s1_q;
  logic [3:0]  s2_q;
  logic [3:0]  s3_q;
  logic [3:0]  st_q;
  logic        xprev_q;
  logic        lprev_q;
  logic        half_xtal_q;
  logic [4:0]  pc_cnt_q;
  logic [4:0]  pc_cnt_d;
  logic        proc_q;
  logic        proc_d;
  logic        sys_q;
  logic [1:0]  dac_q;
  logic        audio_q;
  logic        strap_q;
  logic [2:0]  strap_cnt_q;

  logic        acc;
  logic        hit;
  logic        wr_en;
  logic        relock;
  logic        xtal_rise;
  logic        loop_rise;
  logic        use_loop;
  logic        sleep;
  logic        safe;
  logic [3:0]  cpu_eff;
  logic [4:0]  pc_n;
  logic [2:0]  dac_div [2];

  assign acc       = psel_i & penable_i;
  assign hit       = (paddr_i == PCU_CFG_OFFSET);
  assign wr_en     = acc & pready_q & pwrite_i & hit;
  assign relock    = wr_en & (((pwdata_i & PCU_CFG_WMASK) & PCU_LOOP_FIELDS)
                              != (cfg_q & PCU_LOOP_FIELDS));
  assign sleep     = cfg_q[PCU_SLEEP_BIT];
  assign use_loop  = (mode_q == PCU_LOOP);
  assign xtal_rise = st_q[0] & ~xprev_q;
  assign loop_rise = st_q[1] & ~lprev_q;
  assign safe      = ~proc_q & ~st_q[0];

  // apb slave: one wait state, then ready with data or error
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= acc & ~pready_q;
      pslverr_q <= acc & ~pready_q & ~hit;
      if (acc && !pready_q && !pwrite_i && hit) begin
        prdata_q <= {locked_q, cfg_q[30:0]};
      end else begin
        prdata_q <= 32'h0;
      end
    end
  end

  // configuration register; lock bit and reserved bits not stored
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cfg_q <= PCU_CFG_RESET;
    end else if (wr_en) begin
      cfg_q <= pwdata_i & PCU_CFG_WMASK;
    end
  end

  // lock counter restarts on power-down or loop reprogramming
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lock_cnt_q <= 32'h0;
      locked_q   <= 1'b0;
    end else if (cfg_q[PCU_PDOWN_BIT] || relock) begin
      lock_cnt_q <= 32'h0;
      locked_q   <= 1'b0;
    end else if (!locked_q) begin
      lock_cnt_q <= lock_cnt_q + 32'h1;
      locked_q   <= (lock_cnt_q == LOCK_CYC - 1);
    end
  end

  // pin synchronisers: a level counts once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
    end else begin
      s1_q <= {audio_strap_i, external_audio_clock_pin_i, loop_clk_i, crystal_input_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        st_q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        st_q[i] <= s3_q[i];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      xprev_q     <= 1'b0;
      lprev_q     <= 1'b0;
      half_xtal_q <= 1'b0;
    end else begin
      xprev_q <= st_q[0];
      lprev_q <= st_q[1];
      if (xtal_rise) begin
        half_xtal_q <= ~half_xtal_q;
      end
    end
  end

  // strap caught once the synchroniser has filled after reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      strap_cnt_q <= 3'h0;
      strap_q     <= 1'b0;
    end else if (strap_cnt_q <= PCU_STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 3'h1;
      strap_q     <= st_q[3];
    end
  end

  // source selection: change only while processor clock and crystal are low
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mode_q <= PCU_BYPASS;
    end else begin
      case (mode_q)
        PCU_BYPASS: begin
          if (cfg_q[PCU_ENABLE_BIT]) begin
            mode_q <= PCU_WAIT_LOCK;
          end
        end
        PCU_WAIT_LOCK: begin
          if (!cfg_q[PCU_ENABLE_BIT]) begin
            mode_q <= PCU_BYPASS;
          end else if (locked_q && safe) begin
            mode_q <= PCU_LOOP;
          end
        end
        PCU_LOOP: begin
          if ((!cfg_q[PCU_ENABLE_BIT] || !locked_q) && safe) begin
            mode_q <= PCU_BYPASS;
          end
        end
        default: begin
          mode_q <= PCU_BYPASS;
        end
      endcase
    end
  end

  assign cpu_eff = (cfg_q[PCU_CPU_DIV_LSB +: 3] == 3'h0) ? 4'h8
                   : {1'b0, cfg_q[PCU_CPU_DIV_LSB +: 3]};
  assign pc_n = (cfg_q[PCU_VCO_OUT_LSB +: 2] == PCU_VCO_HALF) ? {cpu_eff, 1'b0}
                : {1'b0, cpu_eff};

  always_comb begin
    pc_cnt_d = pc_cnt_q;
    if (!use_loop) begin
      pc_cnt_d = pc_n - 5'h1;
    end else if (loop_rise) begin
      pc_cnt_d = (pc_cnt_q >= pc_n - 5'h1) ? 5'h0 : pc_cnt_q + 5'h1;
    end
    if (sleep) begin
      proc_d = 1'b0;
    end else if (!use_loop) begin
      proc_d = st_q[0];
    end else if (pc_n == 5'h1) begin
      proc_d = st_q[1];
    end else begin
      proc_d = (pc_cnt_d < (pc_n >> 1)) && (pc_cnt_q != pc_n - 5'h1 || loop_rise);
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      pc_cnt_q <= 5'h0;
      proc_q   <= 1'b0;
      sys_q    <= 1'b0;
    end else begin
      pc_cnt_q <= pc_cnt_d;
      proc_q   <= proc_d;
      if (sleep) begin
        sys_q <= 1'b0;
      end else if (proc_d && !proc_q) begin
        sys_q <= ~sys_q;
      end
    end
  end

  // dac clock divisors from select field
  always_comb begin
    logic [2:0] sel;
    sel = cfg_q[PCU_DAC_SEL_LSB +: 3];
    if (cfg_q[PCU_IN_HALF_BIT]) begin
      dac_div[0] = 3'h2 + ((sel >= 3'h6) ? 3'h2 : (sel >= 3'h3) ? 3'h1 : 3'h0);
      dac_div[1] = 3'h2 + ((sel == 3'h1 || sel == 3'h4 || sel == 3'h7) ? 3'h1
                   : (sel == 3'h2 || sel == 3'h5) ? 3'h2 : 3'h0);
    end else begin
      dac_div[0] = sel[1] ? 3'h2 : 3'h1;
      dac_div[1] = sel[0] ? 3'h1 : 3'h2;
    end
  end

  for (genvar d = 0; d < 2; d++) begin : g_dac
    logic [1:0] cnt_q;
    logic [1:0] cnt_d;
    always_comb begin
      cnt_d = cnt_q;
      if (xtal_rise) begin
        cnt_d = ({1'b0, cnt_q} >= dac_div[d] - 3'h1) ? 2'h0 : cnt_q + 2'h1;
      end
    end
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        cnt_q    <= 2'h0;
        dac_q[d] <= 1'b0;
      end else begin
        cnt_q <= cnt_d;
        if (sleep) begin
          dac_q[d] <= 1'b0;
        end else if (!use_loop || dac_div[d] == 3'h1) begin
          dac_q[d] <= st_q[0];
        end else begin
          dac_q[d] <= ({1'b0, cnt_d} < ((dac_div[d] == 3'h4) ? 3'h2 : 3'h1));
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      audio_q <= 1'b0;
    end else if (sleep) begin
      audio_q <= 1'b0;
    end else if (strap_q) begin
      audio_q <= st_q[2];
    end else begin
      audio_q <= cfg_q[PCU_AUD_XTAL_BIT] ? st_q[0] : half_xtal_q;
    end
  end

  assign prdata_o               = prdata_q;
  assign pready_o               = pready_q;
  assign pslverr_o              = pslverr_q;
  assign processor_clock_o      = proc_q;
  assign system_half_clock_o    = sys_q;
  assign dac_master_clock_one_o = dac_q[0];
  assign dac_master_clock_two_o = dac_q[1];
  assign audio_clock_o          = audio_q;
  assign loop_locked_o          = locked_q;
  assign loop_power_down_o      = cfg_q[PCU_PDOWN_BIT];
  assign sleep_o                = cfg_q[PCU_SLEEP_BIT];
  assign loop_in_half_o         = cfg_q[PCU_IN_HALF_BIT];
  assign reference_divider_o    = cfg_q[PCU_REF_DIV_LSB +: 5];
  assign feedback_divider_o     = cfg_q[PCU_FB_DIV_LSB +: 8];
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  a_half_rate: assert property ($rose(proc_q) |-> sys_q != $past(sys_q))
    else $error("system clock missed a toggle");
  a_bypass_xtal: assert property (!use_loop && !sleep |=> proc_q == $past(st_q[0]))
    else $error("bypass does not pass the crystal");
  a_switch_lock: assert property ($rose(use_loop) |-> $past(locked_q) && $past(safe))
    else $error("loop selected before lock");
  a_lock_read: assert property (pready_q && $past(!pwrite_i && hit)
    |-> prdata_q[31] == $past(locked_q))
    else $error("lock bit read wrong");
  a_lock_time: assert property ($rose(locked_q) |-> $past(lock_cnt_q) == LOCK_CYC - 1)
    else $error("lock reported at wrong count");
  a_cfg_write: assert property (wr_en |=> cfg_q == ($past(pwdata_i) & PCU_CFG_WMASK))
    else $error("config write not stored");
  a_lock_ro: assert property (wr_en && !locked_q && lock_cnt_q != LOCK_CYC - 1
    |=> !locked_q)
    else $error("write changed lock state");
  a_sleep_stop: assert property (sleep ##1 sleep |-> !proc_q && !sys_q && !audio_q)
    else $error("clocks run in sleep");
  a_pdown_unlock: assert property (cfg_q[PCU_PDOWN_BIT] |-> !locked_q)
    else $error("locked while powered down");

endmodule

// ===== hw/pcu_pkg.sv
// pcu_pkg: constants and types for the loop clock configuration unit
// Contract
// - system clock always half processor clock
// - enable bit 0 routes crystal to outputs
// - switch to loop waits for lock
// - bit 31 reads loop lock state
// - lock takes up to 10 ms
// - bits 30:28 pick both DAC clocks
// - bit 23 halves the loop input
// - strap picks pin, else bit 22 picks
// - bits 19:12 hold feedback divider
// - bits 8:4 hold reference divider
// - bit 11 stops all clocks
// - bit 9 powers the loop down
// - processor clock is VCO result over divider
// - divider code zero divides by eight
// - DAC clocks 50 or 33 percent duty
// - loop/crystal switch-over is glitch free; code gates it on processor clock and crystal low, not DAC clocks
package pcu_pkg;
  localparam logic [11:0] PCU_CFG_OFFSET    = 12'h180;
  localparam logic [31:0] PCU_CFG_RESET     = 32'h0202_0088;
  localparam logic [31:0] PCU_CFG_WMASK     = 32'h77cf_fbff;
  localparam logic [31:0] PCU_LOOP_FIELDS   = 32'h008f_f3f0;
  localparam int          PCU_LOCK_BIT      = 31;
  localparam int          PCU_DAC_SEL_LSB   = 28;
  localparam int          PCU_CPU_DIV_LSB   = 24;
  localparam int          PCU_IN_HALF_BIT   = 23;
  localparam int          PCU_AUD_XTAL_BIT  = 22;
  localparam int          PCU_FB_DIV_LSB    = 12;
  localparam int          PCU_SLEEP_BIT     = 11;
  localparam int          PCU_PDOWN_BIT     = 9;
  localparam int          PCU_REF_DIV_LSB   = 4;
  localparam int          PCU_VCO_OUT_LSB   = 2;
  localparam int          PCU_ENABLE_BIT    = 0;
  localparam logic [1:0]  PCU_VCO_HALF      = 2'h2;
  localparam logic [2:0]  PCU_STRAP_WAIT    = 3'h4;
  localparam int unsigned PCU_CLK_HZ        = 10_000_000;
  localparam int unsigned PCU_LOCK_TIME_MS  = 10;
  localparam int unsigned PCU_LOCK_CYCLES   = PCU_LOCK_TIME_MS * (PCU_CLK_HZ / 1000);

  typedef enum logic [1:0] {
    PCU_BYPASS,
    PCU_WAIT_LOCK,
    PCU_LOOP
  } pcu_mode_t;
endpackage

// ===== verification/tb_pcu_top.sv
// self-checking bench for the clock configuration unit
`timescale 1ns/1ps
module tb_pcu_top;
  import pcu_pkg::*;
  logic        clk_i = 0, srst_i = 1, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 12'h0;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, v, cur = 32'h0202_0088;
  logic        pready_o, pslverr_o, er, xtal = 0, vco = 0, ext = 0, strap = 0;
  logic        pclk, sclk, d1, d2, aud, lock, pdn, slp, inh;
  logic [4:0]  refd;
  logic [7:0]  fbd;
  int          bad_count = 0, checked = 0, seed = 32'h2fa69ab5, ph = 0, hi, n;
  int          r[8];
  int          cd[4] = '{1, 3, 0, 2};
  int          vo[4] = '{1, 1, 1, 2};

  always #50 clk_i = ~clk_i;

  // pins run slower than clk/6, each at its own rate
  always @(posedge clk_i) begin
    ph <= ph + 1;
    if (ph % 4 == 3) xtal <= ~xtal;
    if (ph % 5 == 4) vco <= ~vco;
    if (ph % 6 == 5) ext <= ~ext;
  end

  pcu_top #(.LOCK_CYC(20)) pcu_top_i (
    .clk_i(clk_i), .srst_i(srst_i), .paddr_i(paddr_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .crystal_input_i(xtal), .loop_clk_i(vco), .external_audio_clock_pin_i(ext),
    .audio_strap_i(strap), .processor_clock_o(pclk), .system_half_clock_o(sclk),
    .dac_master_clock_one_o(d1), .dac_master_clock_two_o(d2),
    .audio_clock_o(aud), .loop_locked_o(lock), .loop_power_down_o(pdn),
    .sleep_o(slp), .loop_in_half_o(inh), .reference_divider_o(refd),
    .feedback_divider_o(fbd));

  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic check(logic [31:0] s, logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  function automatic logic [31:0] nr(int a, int b, int t);
    return {31'h0, (a - b <= t) && (b - a <= t)};
  endfunction

  // readback view: lock on top, reserved bits read zero
  function automatic logic [31:0] ex(logic [31:0] d, logic l);
    return {l, d[30:28], 1'b0, d[26:22], 2'b00, d[19:11], 1'b0, d[9:0]};
  endfunction

  function automatic int dv(logic cs, logic [2:0] s, logic two);
    if (!cs) return two ? (s[0] ? 1 : 2) : (s[1] ? 2 : 1);
    return two ? 2 + s % 3 : 2 + s / 3;
  endfunction

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    k = 0;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready_o !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      close_out();
    end
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
  endtask

  task automatic wr(logic [31:0] d);
    apb(1, 12'h180, d);
    check({31'h0, er}, 32'h0);
  endtask

  // leave loop mode before any other field changes, re-enable last
  task automatic cfg(logic [31:0] d);
    wr(cur & ~32'h1);
    wr(d & ~32'h1);
    if (d[0]) wr(d);
    cur = d;
  endtask

  task automatic wait_lock;
    int k;
    k = 0;
    do begin
      apb(0, 12'h180, 32'h0);
      k++;
    end while (rd[31] !== 1'b1 && k < 8);
    check({31'h0, rd[31]}, 32'h1);
    check({31'h0, lock}, 32'h1);
  endtask

  task automatic win(int c);
    logic [7:0] p, q;
    r = '{default: 0};
    hi = 0;
    p = {aud, d2, d1, sclk, pclk, ext, vco, xtal};
    repeat (c) begin
      @(posedge clk_i);
      q = {aud, d2, d1, sclk, pclk, ext, vco, xtal};
      for (int i = 0; i < 8; i++) if (q[i] && !p[i]) r[i]++;
      hi += d2;
      p = q;
    end
  endtask

  initial begin
    repeat (4) @(posedge clk_i);
    srst_i <= 0;
    apb(0, 12'h180, 32'h0);
    check(rd, 32'h0202_0088);
    check({inh, pdn, slp, refd, fbd}, {3'h0, 5'h08, 8'h20});
    apb(1, 12'h184, 32'hffff_ffff);
    check({31'h0, er}, 32'h1);
    apb(0, 12'h184, 32'h0);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    wait_lock();
    check(rd, 32'h8202_0088);
    $display("reset and decode test done");
    for (int k = 0; k < 6; k++) begin
      v = $random(seed) & 32'hf7cf_fbfd;
      v[11] = 1'b0;
      v[0] = 1'b0;
      v[9] = (k == 2);
      if (k == 1) v = v | 32'h8000_0000;
      cfg(v);
      apb(0, 12'h180, 32'h0);
      check(rd, ex(v, 1'b0));
      check({inh, pdn, slp, refd, fbd}, {v[23], v[9], v[11], v[8:4], v[19:12]});
      if (v[9]) begin
        repeat (40) @(posedge clk_i);
        apb(0, 12'h180, 32'h0);
        check({31'h0, rd[31]}, 32'h0);
        check({31'h0, lock}, 32'h0);
      end else wait_lock();
    end
    $display("register test done");
    cfg(32'h0202_0088);
    win(160);
    check(nr(r[3], r[0], 1), 32'h1);
    check(nr(r[4], r[3] / 2, 1), 32'h1);
    check(nr(r[5] + r[6], 2 * r[0], 2), 32'h1);
    check(nr(r[7], r[0] / 2, 1), 32'h1);
    cfg(32'h0242_0088);
    win(160);
    check(nr(r[7], r[0], 1), 32'h1);
    cfg(32'h0000_2281);
    win(160);
    check(nr(r[3], r[0], 1), 32'h1);
    $display("bypass test done");
    for (int i = 0; i < 4; i++) begin
      v = 32'h0000_2081;
      v[26:24] = cd[i][2:0];
      v[3:2] = vo[i][1:0];
      n = (cd[i] == 0 ? 8 : cd[i]) * vo[i];
      cfg(v);
      wait_lock();
      repeat (20) @(posedge clk_i);
      win(100 * n);
      check(nr(r[3], r[1] / n, 1), 32'h1);
      check(nr(r[4], r[3] / 2, 1), 32'h1);
    end
    $display("divider test done");
    for (int i = 0; i < 12; i++) begin
      v = 32'h0000_2081 | (i < 8 ? 32'h0080_0000 : 32'h0);
      v[30:28] = i[2:0];
      cfg(v);
      wait_lock();
      repeat (20) @(posedge clk_i);
      win(240);
      check(nr(r[5], r[0] / dv(v[23], v[30:28], 0), 1), 32'h1);
      check(nr(r[6], r[0] / dv(v[23], v[30:28], 1), 1), 32'h1);
      check(nr(hi, dv(v[23], v[30:28], 1) == 3 ? 80 : 120, 12), 32'h1);
    end
    $display("dac clock test done");
    cfg(32'h0202_0888);
    repeat (5) @(posedge clk_i);
    win(100);
    check(r[3] + r[4] + r[5] + r[6] + r[7], 32'h0);
    cfg(32'h0202_0088);
    repeat (10) @(posedge clk_i);
    win(80);
    check({31'h0, r[3] > 0}, 32'h1);
    $display("sleep test done");
    srst_i <= 1;
    strap <= 1;
    repeat (4) @(posedge clk_i);
    srst_i <= 0;
    repeat (12) @(posedge clk_i);
    win(180);
    check(nr(r[7], r[2], 1), 32'h1);
    $display("strap test done");
    close_out();
  end
endmodule
